// ===== rqf_top.sv
// Purpose: Multicast hash word 3, queue water marks and frame count.
// Assumes: Host bus is a 16-bit synchronous read/write strobe port.
// Notes: Hash words 0 to 2 are held elsewhere and enter as a port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Accept a multicast frame whose hashed table bit is one.
// - Discard a multicast frame whose hashed table bit is zero.
// - Receive-all with multicast-by-address set accepts every multicast.
// - Hash is top six CRC bits; two pick word, four pick bit.
// - Low water mark, 12 bits in double words, resets to 0x600.
// - High water mark, 12 bits free space, resets to 0x400.
// - Overrun water mark, 12 bits free space, resets to 0x040.
// - Read-only frame count in bits 15:8, latched on interrupt clear.
module rqf_top #(
  parameter int QUEUE_DW = 3072,
  parameter int DEPTH = rqf_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Host register port.
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Control from neighbouring registers.
  input wire logic [15:0] receive_control_one,
  input wire logic [47:0] hash_words_0_2,
  input wire logic rx_int_clear,
  // Frame decision from the receive MAC.
  input wire logic frame_check,
  input wire logic frame_is_mcast,
  input wire logic [47:0] frame_dest_addr,
  output logic frame_accept,
  output logic frame_drop,
  // Receive data stream into the queue.
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [rqf_pkg::FIFO_W-1:0] rx_data,
  input wire logic rx_frame_end,
  // Queue drain towards the host.
  output logic host_valid,
  input wire logic host_ready,
  output logic [rqf_pkg::FIFO_W-1:0] host_data,
  input wire logic host_frame_done,
  // Queue space accounting.
  input wire logic [11:0] queue_used_dw,
  // Flow control outputs.
  output logic flow_pause,
  output logic flow_overrun
);
  import rqf_pkg::*;

  typedef enum logic [1:0] {FC_IDLE, FC_PAUSE} rqf_fc_t;

  logic [15:0] hash3_q, hash3_d;
  logic [MARK_W-1:0] low_q, low_d, high_q, high_d, ovr_q, ovr_d;
  logic [7:0] fcnt_lat_q, fcnt_lat_d, frames_q, frames_d;
  logic [7:0] rsvd_q, rsvd_d;
  logic [15:0] rdata_q, rdata_d;
  logic accept_q, accept_d, drop_q, drop_d;
  logic ovr_flag_q, ovr_flag_d;
  rqf_fc_t fc_q, fc_d;
  logic [HASH_W-1:0] hidx;
  logic [63:0] table_bits;
  logic [MARK_W:0] free_dw;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] o);
    hit = (a == o);
  endfunction

  rqf_hash u_hash (
    .dest_addr(frame_dest_addr),
    .hash_index(hidx)
  );

  rqf_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(host_valid),
    .out_ready(host_ready),
    .out_data(host_data),
    .level()
  );

  assign table_bits = {hash3_q, hash_words_0_2};
  assign free_dw = (QUEUE_DW[MARK_W:0] > {1'b0, queue_used_dw}) ?
      QUEUE_DW[MARK_W:0] - {1'b0, queue_used_dw} : '0;
  assign reg_rdata = rdata_q;
  assign frame_accept = accept_q;
  assign frame_drop = drop_q;
  assign flow_pause = (fc_q == FC_PAUSE);
  assign flow_overrun = ovr_flag_q;

  // Register writes.
  always_comb begin
    hash3_d = hash3_q;
    low_d = low_q;
    high_d = high_q;
    ovr_d = ovr_q;
    rsvd_d = rsvd_q;
    if (reg_wr) begin
      if (hit(reg_addr, HASH3_OFS)) begin
        hash3_d = reg_wdata;
      end
      if (hit(reg_addr, LOW_OFS)) begin
        low_d = reg_wdata[MARK_W-1:0];
      end
      if (hit(reg_addr, HIGH_OFS)) begin
        high_d = reg_wdata[MARK_W-1:0];
      end
      if (hit(reg_addr, OVR_OFS)) begin
        ovr_d = reg_wdata[MARK_W-1:0];
      end
      if (hit(reg_addr, FCNT_OFS)) begin
        rsvd_d = reg_wdata[7:0];
      end
    end
  end

  // Register reads, one cycle after the strobe.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = 16'h0000;
      if (hit(reg_addr, HASH3_OFS)) begin
        rdata_d = hash3_q;
      end
      if (hit(reg_addr, LOW_OFS)) begin
        rdata_d = {4'h0, low_q};
      end
      if (hit(reg_addr, HIGH_OFS)) begin
        rdata_d = {4'h0, high_q};
      end
      if (hit(reg_addr, OVR_OFS)) begin
        rdata_d = {4'h0, ovr_q};
      end
      if (hit(reg_addr, FCNT_OFS)) begin
        rdata_d = {fcnt_lat_q, rsvd_q};
      end
    end
  end

  // Frame count tracking and latching on interrupt clear.
  always_comb begin
    frames_d = frames_q;
    if (rx_frame_end && !host_frame_done && frames_q != 8'hff) begin
      frames_d = frames_q + 8'h01;
    end else if (host_frame_done && !rx_frame_end && frames_q != 8'h00) begin
      frames_d = frames_q - 8'h01;
    end
    fcnt_lat_d = rx_int_clear ? frames_d : fcnt_lat_q;
  end

  // Multicast filter decision.
  always_comb begin
    accept_d = 1'b0;
    drop_d = 1'b0;
    if (frame_check) begin
      if (!frame_is_mcast) begin
        accept_d = 1'b1;
      end else if (receive_control_one[CTL_RXALL_BIT] &&
                   receive_control_one[CTL_MCADDR_BIT]) begin
        accept_d = 1'b1;
      end else if (table_bits[hidx]) begin
        accept_d = 1'b1;
      end else begin
        drop_d = 1'b1;
      end
    end
  end

  // Flow control state.
  always_comb begin
    fc_d = fc_q;
    case (fc_q)
      FC_IDLE: begin
        if (free_dw < {1'b0, high_q}) begin
          fc_d = FC_PAUSE;
        end
      end
      FC_PAUSE: begin
        if (free_dw > {1'b0, low_q}) begin
          fc_d = FC_IDLE;
        end
      end
      default: begin
        fc_d = FC_IDLE;
      end
    endcase
    ovr_flag_d = (free_dw < {1'b0, ovr_q});
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hash3_q <= HASH3_RST;
      low_q <= LOW_RST;
      high_q <= HIGH_RST;
      ovr_q <= OVR_RST;
      rsvd_q <= RSVD_RST;
      rdata_q <= 16'h0000;
      frames_q <= 8'h00;
      fcnt_lat_q <= 8'h00;
      accept_q <= 1'b0;
      drop_q <= 1'b0;
      fc_q <= FC_IDLE;
      ovr_flag_q <= 1'b0;
    end else begin
      hash3_q <= hash3_d;
      low_q <= low_d;
      high_q <= high_d;
      ovr_q <= ovr_d;
      rsvd_q <= rsvd_d;
      rdata_q <= rdata_d;
      frames_q <= frames_d;
      fcnt_lat_q <= fcnt_lat_d;
      accept_q <= accept_d;
      drop_q <= drop_d;
      fc_q <= fc_d;
      ovr_flag_q <= ovr_flag_d;
    end
  end

  a_hash_accept: assert property (@(posedge sys_clk) disable iff (rst)
    frame_check && frame_is_mcast && table_bits[hidx] |=> frame_accept)
    else $error("Multicast with set hash bit not accepted.");
  a_hash_drop: assert property (@(posedge sys_clk) disable iff (rst)
    frame_check && frame_is_mcast && !table_bits[hidx] &&
    !(receive_control_one[4] && receive_control_one[8]) |=> frame_drop)
    else $error("Multicast with clear hash bit not dropped.");
  a_all_mcast: assert property (@(posedge sys_clk) disable iff (rst)
    frame_check && receive_control_one[4] && receive_control_one[8]
    |=> frame_accept && !frame_drop)
    else $error("Receive-all multicast not accepted.");
  a_hash_word: assert property (@(posedge sys_clk) disable iff (rst)
    frame_check && frame_is_mcast && hidx[5:4] == 2'b11 &&
    !(receive_control_one[4] && receive_control_one[8])
    |=> frame_accept == $past(hash3_q[hidx[3:0]]))
    else $error("Hash word 3 bit selection wrong.");
  a_low_mark: assert property (@(posedge sys_clk)
    rst |=> low_q == 12'h600)
    else $error("Low water mark reset wrong.");
  a_high_mark: assert property (@(posedge sys_clk)
    rst |=> high_q == 12'h400)
    else $error("High water mark reset wrong.");
  a_ovr_mark: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == 10'h1b4 |=> ovr_q == $past(reg_wdata[11:0]))
    else $error("Overrun water mark write lost.");
  a_count_ro: assert property (@(posedge sys_clk) disable iff (rst)
    !rx_int_clear |=> fcnt_lat_q == $past(fcnt_lat_q))
    else $error("Frame count changed without clear.");
  a_count_read: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == 10'h1b8 |=> reg_rdata[15:8] == $past(fcnt_lat_q))
    else $error("Frame count read value wrong.");
  a_flow_on: assert property (@(posedge sys_clk) disable iff (rst)
    !flow_pause && free_dw < {1'b0, high_q} |=> flow_pause)
    else $error("Flow control not asserted below high mark.");
  // Further checks on hash word 3, the marks, the filter verdicts and the latched count.
  a_hash_reset: assert property (@(posedge sys_clk)
    rst |=> hash3_q == HASH3_RST)
    else $error("Hash word 3 reset wrong.");
  a_one_verdict: assert property (@(posedge sys_clk) disable iff (rst)
    frame_check |=> frame_accept != frame_drop)
    else $error("Filter verdict not exactly one.");
  a_no_verdict: assert property (@(posedge sys_clk) disable iff (rst)
    !frame_check |=> !frame_accept && !frame_drop)
    else $error("Filter verdict without a frame.");
  a_low_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == LOW_OFS |=> low_q == $past(reg_wdata[11:0]))
    else $error("Low water mark write lost.");
  a_low_read: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == LOW_OFS |=> reg_rdata == {4'h0, $past(low_q)})
    else $error("Low water mark read wrong.");
  a_high_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && reg_addr == HIGH_OFS |=> high_q == $past(reg_wdata[11:0]))
    else $error("High water mark write lost.");
  a_high_read: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == HIGH_OFS |=> reg_rdata == {4'h0, $past(high_q)})
    else $error("High water mark read wrong.");
  a_ovr_reset: assert property (@(posedge sys_clk)
    rst |=> ovr_q == OVR_RST)
    else $error("Overrun water mark reset wrong.");
  a_ovr_read: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == OVR_OFS |=> reg_rdata == {4'h0, $past(ovr_q)})
    else $error("Overrun water mark read wrong.");
  a_ovr_set: assert property (@(posedge sys_clk) disable iff (rst)
    free_dw < {1'b0, ovr_q} |=> flow_overrun)
    else $error("Overrun flag not set below mark.");
  a_ovr_clear: assert property (@(posedge sys_clk) disable iff (rst)
    free_dw >= {1'b0, ovr_q} |=> !flow_overrun)
    else $error("Overrun flag set above mark.");
  a_flow_off: assert property (@(posedge sys_clk) disable iff (rst)
    flow_pause && free_dw > {1'b0, low_q} |=> !flow_pause)
    else $error("Flow control not released above low mark.");
  a_pause_hold: assert property (@(posedge sys_clk) disable iff (rst)
    flow_pause && free_dw <= {1'b0, low_q} |=> flow_pause)
    else $error("Flow control released too early.");
  a_idle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !flow_pause && free_dw >= {1'b0, high_q} |=> !flow_pause)
    else $error("Flow control asserted too early.");
  a_count_latch: assert property (@(posedge sys_clk) disable iff (rst)
    rx_int_clear |=> fcnt_lat_q == frames_q)
    else $error("Frame count not latched on clear.");
endmodule
`default_nettype wire

// ===== rqf_pkg.sv
// Purpose: Shared constants for the receive queue filter and flow marks.
// Assumes: 16-bit host register bus, byte addresses as printed.
// Notes: Water marks count double words of free receive queue space.
package rqf_pkg;
  localparam logic [9:0] HASH3_OFS = 10'h1a6;
  localparam logic [9:0] LOW_OFS = 10'h1b0;
  localparam logic [9:0] HIGH_OFS = 10'h1b2;
  localparam logic [9:0] OVR_OFS = 10'h1b4;
  localparam logic [9:0] FCNT_OFS = 10'h1b8;
  localparam logic [15:0] HASH3_RST = 16'h0000;
  localparam logic [11:0] LOW_RST = 12'h600;
  localparam logic [11:0] HIGH_RST = 12'h400;
  localparam logic [11:0] OVR_RST = 12'h040;
  localparam logic [7:0] RSVD_RST = 8'h00;
  localparam int MARK_W = 12;
  localparam int FCNT_LSB = 8;
  localparam int CTL_RXALL_BIT = 4;
  localparam int CTL_MCADDR_BIT = 8;
  localparam int HASH_W = 6;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 16;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
endpackage

// ===== rqf_fifo.sv
// Purpose: Valid/ready FIFO in the receive data path.
// Assumes: Depth is a power of two.
// Notes: Full and empty derive from an occupancy counter.
`timescale 1ns/1ps
`default_nettype none
module rqf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Occupancy.
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign level = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ===== rqf_hash.sv
// Purpose: Six-bit multicast hash index from a destination address.
// Assumes: Address arrives as 48 bits, first wire bit at bit 0.
// Notes: Combinational CRC over all 48 bits.
`timescale 1ns/1ps
`default_nettype none
module rqf_hash (
  // Address in.
  input wire logic [47:0] dest_addr,
  // Index out.
  output logic [rqf_pkg::HASH_W-1:0] hash_index
);
  import rqf_pkg::*;
  logic [31:0] crc;

  always_comb begin
    crc = 32'hffffffff;
    for (int i = 0; i < 48; i++) begin
      if (crc[31] ^ dest_addr[i]) begin
        crc = (crc << 1) ^ CRC_POLY;
      end else begin
        crc = crc << 1;
      end
    end
    hash_index = crc[31:32-HASH_W];
  end
endmodule
`default_nettype wire

// ===== rqf_host_model.sv
// Purpose: Host processor model on the register strobe port.
// Assumes: Strobes change at the falling edge of sys_clk.
// Notes: Read data is taken one cycle after the read strobe is dropped.
`timescale 1ns/1ps
`default_nettype none
module rqf_host_model (
  // Clock.
  input wire logic sys_clk,
  // Register port.
  output logic [9:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  import rqf_pkg::*;
  initial begin
    reg_addr = 10'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // The count is read from the frame count register at FCNT_OFS.
  task automatic rd_count(output logic [15:0] d);
    rd(FCNT_OFS, d);
  endtask
endmodule
`default_nettype wire

// ===== test_rqf_top.sv
// Purpose: Self-checking bench for the receive filter and flow marks.
// Assumes: Inputs change at the falling edge of sys_clk.
// Notes: Expected values come from the bench's own hash and tables.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_rqf_top;
  import rqf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] reg_addr;
  logic reg_wr, reg_rd, frame_check, frame_is_mcast, frame_accept;
  logic [15:0] reg_wdata, reg_rdata, receive_control_one, rx_data, d, h3;
  logic [47:0] hash_words_0_2, frame_dest_addr, da;
  logic frame_drop, rx_valid, rx_ready, rx_frame_end, rx_int_clear;
  logic host_valid, host_ready, host_frame_done, flow_pause, flow_overrun;
  logic [15:0] host_data, seed = 16'h0056;
  logic [11:0] queue_used_dw;
  logic [63:0] tbl;
  logic [7:0] k;
  logic [15:0] q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 sys_clk = ~sys_clk;
  rqf_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  rqf_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .receive_control_one(receive_control_one),
    .hash_words_0_2(hash_words_0_2), .rx_int_clear(rx_int_clear),
    .frame_check(frame_check), .frame_is_mcast(frame_is_mcast),
    .frame_dest_addr(frame_dest_addr), .frame_accept(frame_accept),
    .frame_drop(frame_drop), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_frame_end(rx_frame_end),
    .host_valid(host_valid), .host_ready(host_ready),
    .host_data(host_data), .host_frame_done(host_frame_done),
    .queue_used_dw(queue_used_dw), .flow_pause(flow_pause),
    .flow_overrun(flow_overrun));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 48; i++) begin
      c = (c[31] ^ a[i]) ? ({c[30:0], 1'b0} ^ CRC_POLY) : {c[30:0], 1'b0};
    end
    return c[31:26];
  endfunction
  task automatic end_sim();
    $display("Counts: %0d checked, %0d mismatches", samples_checked,
      n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic frame(input logic mc, input logic [47:0] a, input logic e);
    @(negedge sys_clk);
    frame_check = 1'b1;
    frame_is_mcast = mc;
    frame_dest_addr = a;
    @(negedge sys_clk);
    frame_check = 1'b0;
    frame_dest_addr = ~a;
    `CHK("frame_accept", e, frame_accept)
    `CHK("frame_drop", ~e, frame_drop)
  endtask
  task automatic ev(input logic [2:0] s);
    @(negedge sys_clk);
    {rx_frame_end, rx_int_clear, host_frame_done} = s;
    @(negedge sys_clk);
    {rx_frame_end, rx_int_clear, host_frame_done} = 3'b000;
  endtask
  task automatic used(input logic [11:0] u, input logic p, input logic o);
    @(negedge sys_clk);
    queue_used_dw = u;
    repeat (2) @(negedge sys_clk);
    `CHK("flow_pause", p, flow_pause)
    `CHK("flow_overrun", o, flow_overrun)
  endtask
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {frame_check, frame_is_mcast, rx_valid, host_ready} = 4'h0;
    {rx_frame_end, rx_int_clear, host_frame_done} = 3'b000;
    receive_control_one = 16'h0000;
    frame_dest_addr = 48'h0;
    rx_data = 16'h0000;
    queue_used_dw = 12'h000;
    hash_words_0_2 = 48'h0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    host.rd(HASH3_OFS, d);
    `CHK("hash_word_3", 16'h0000, d)
    host.rd(LOW_OFS, d);
    `CHK("low_mark", 16'h0600, d)
    host.rd(HIGH_OFS, d);
    `CHK("high_mark", 16'h0400, d)
    host.rd(OVR_OFS, d);
    `CHK("overrun_mark", 16'h0040, d)
    host.rd(10'h1a8, d);
    `CHK("unmapped", 16'h0000, d)
    host.wr(OVR_OFS, 16'hffff);
    host.rd(OVR_OFS, d);
    `CHK("overrun_mark_w", 16'h0fff, d)
    host.wr(OVR_OFS, 16'h0040);
    host.wr(FCNT_OFS, 16'hffff);
    host.rd_count(d);
    `CHK("frame_count_ro", 16'h00ff, d)
    $display("Registers test done");
    for (int m = 0; m < 4; m++) begin
      seed = nxt(seed);
      h3 = seed;
      host.wr(HASH3_OFS, h3);
      seed = nxt(seed);
      hash_words_0_2 = {seed, ~seed, seed ^ 16'h5a3c};
      tbl = {h3, hash_words_0_2};
      receive_control_one = m == 2 ? 16'h0110 : m == 1 ? 16'h0010 :
          m == 3 ? 16'h0100 : 16'h0000;
      for (int i = 0; i < 16; i++) begin
        seed = nxt(seed);
        da = {seed, nxt(seed), ~seed};
        frame(1'b1, da, (m == 2) | tbl[hidx(da)]);
      end
    end
    frame(1'b0, da, 1'b1);
    $display("Filter test done");
    k = {5'h0, seed[2:0]} + 8'h02;
    repeat (k) ev(3'b100);
    ev(3'b010);
    ev(3'b100);
    host.rd_count(d);
    `CHK("frame_count", {k, 8'hff}, d)
    ev(3'b001);
    ev(3'b001);
    ev(3'b010);
    host.rd_count(d);
    `CHK("frame_count_2", {k - 8'h01, 8'hff}, d)
    $display("Frame count test done");
    used(12'd0, 1'b0, 1'b0);
    used(12'd2049, 1'b1, 1'b0);
    used(12'd1536, 1'b1, 1'b0);
    used(12'd1535, 1'b0, 1'b0);
    used(12'd3009, 1'b1, 1'b1);
    used(12'd3008, 1'b1, 1'b0);
    used(12'd0, 1'b0, 1'b0);
    host.wr(HIGH_OFS, 16'h0100);
    used(12'd2049, 1'b0, 1'b0);
    used(12'd2817, 1'b1, 1'b0);
    $display("Flow test done");
    for (int i = 0; i < 32; i++) begin
      @(negedge sys_clk);
      `CHK("rx_ready", 1'b1, rx_ready)
      seed = nxt(seed);
      rx_valid = 1'b1;
      rx_data = seed;
      q.push_back(seed);
    end
    @(negedge sys_clk);
    rx_data = ~rx_data;
    `CHK("rx_ready_full", 1'b0, rx_ready)
    @(negedge sys_clk);
    rx_valid = 1'b0;
    host_ready = 1'b1;
    for (int i = 0; i < 32; i++) begin
      d = q.pop_front();
      `CHK("host_valid", 1'b1, host_valid)
      `CHK("host_data", d, host_data)
      @(negedge sys_clk);
    end
    `CHK("host_valid_empty", 1'b0, host_valid)
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      rx_valid = 1'b1;
      rx_data = seed;
      @(negedge sys_clk);
      `CHK("stream_valid", 1'b1, host_valid)
      `CHK("stream_data", seed, host_data)
    end
    $display("Queue test done");
    end_sim();
  end
endmodule
`default_nettype wire
